/* File: design/system_tick_timer.sv */
`timescale 1ns/1ps
// Functional notes
// - a 24-bit counter counts down and signals a tick when it reaches zero.
// - the counter runs on the processor clock, the only clock of the block.
// - control bit 0 lets the counter run when set and holds it when clear.
// - control bit 1 allows an interrupt request on every zero reached.
// - control bit 16 is set on zero and cleared by a read of that register unless zero is reached in the same cycle.
// - on reaching zero the counter is loaded from reload bits 23:0.
// - reading the current-value register returns the live 24-bit count.
// - any write to the current-value register clears the count, and the flag unless zero is reached in the same cycle.
// - the calibration register offers a default reload in bits 23:0.
// - after reset control reads 0x4 and reload and current read zero.
module system_tick_timer #(
  parameter int COUNT_WIDTH = tick_pkg::COUNT_W
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);
  // refuse widths the register map cannot serve
  if (COUNT_WIDTH != 24) begin : g_bad_width
    $error("system_tick_timer: COUNT_WIDTH must be 24");
  end

  // ==========================================
  // state
  typedef struct packed {
    logic run;
    logic int_en;
    logic zero_flag;
    logic [23:0] reload;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] rdata;
    logic slverr;
    logic ack;
  } regs_s;

  regs_s r_q, r_d;

  logic [23:0] count;
  logic zero_hit;
  logic access, capture, rd_capture, wr_access, rd_access;
  logic sel_ctrl, sel_reload, sel_current, sel_calib, sel_stat, sel_mask;
  logic mapped;
  logic clear_count;

  // ==========================================
  // apb decode: one wait state per transfer
  // first access cycle loads read data into flops, second one completes
  assign access = PSEL && PENABLE;
  assign capture = access && !r_q.ack;
  assign rd_capture = capture && !PWRITE;
  assign wr_access = access && r_q.ack && PWRITE;
  assign rd_access = access && r_q.ack && !PWRITE;

  // address select
  always_comb begin
    sel_ctrl = 1'b0;
    sel_reload = 1'b0;
    sel_current = 1'b0;
    sel_calib = 1'b0;
    sel_stat = 1'b0;
    sel_mask = 1'b0;
    if (PADDR == tick_pkg::OFF_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (PADDR == tick_pkg::OFF_RELOAD) begin
      sel_reload = 1'b1;
    end else if (PADDR == tick_pkg::OFF_CURRENT) begin
      sel_current = 1'b1;
    end else if (PADDR == tick_pkg::OFF_CALIB) begin
      sel_calib = 1'b1;
    end else if (PADDR == tick_pkg::OFF_IRQ_STATUS) begin
      sel_stat = 1'b1;
    end else if (PADDR == tick_pkg::OFF_IRQ_MASK) begin
      sel_mask = 1'b1;
    end
  end

  assign mapped = sel_ctrl | sel_reload | sel_current | sel_calib | sel_stat | sel_mask;

  assign clear_count = wr_access && sel_current;

  // ==========================================
  // counter
  tick_counter #(
    .WIDTH(COUNT_WIDTH)
  ) u_counter (
    .clk(CLK),
    .rst(RST),
    .enable(r_q.run),
    .clear(clear_count),
    .reload(r_q.reload),
    .count(count),
    .zero_hit(zero_hit)
  );

  // ==========================================
  // register next state
  always_comb begin
    r_d = r_q;
    r_d.slverr = 1'b0;
    r_d.ack = capture;
    // control, reload and mask writes, flag clears
    if (wr_access && sel_ctrl) begin
      r_d.run = PWDATA[tick_pkg::CTRL_ENABLE_BIT];
      r_d.int_en = PWDATA[tick_pkg::CTRL_INT_EN_BIT];
    end
    if (wr_access && sel_reload) begin
      r_d.reload = PWDATA[23:0];
    end
    if (wr_access && sel_mask) begin
      r_d.irq_mask = PWDATA[1:0];
    end
    if (rd_capture && sel_ctrl) begin
      r_d.zero_flag = 1'b0;
    end
    if (clear_count) begin
      r_d.zero_flag = 1'b0;
    end
    // write one to clear status
    if (wr_access && sel_stat) begin
      r_d.irq_status = r_q.irq_status & ~PWDATA[1:0];
    end
    if (zero_hit) begin
      r_d.zero_flag = 1'b1;
      r_d.irq_status[0] = 1'b1;
    end
    if (zero_hit && r_q.int_en) begin
      r_d.irq_status[1] = 1'b1;
    end
    // read data mux
    r_d.rdata = 32'h0000_0000;
    if (rd_capture) begin
      if (sel_ctrl) begin
        r_d.rdata[tick_pkg::CTRL_FIXED_BIT] = 1'b1;
        r_d.rdata[tick_pkg::CTRL_ENABLE_BIT] = r_q.run;
        r_d.rdata[tick_pkg::CTRL_INT_EN_BIT] = r_q.int_en;
        r_d.rdata[tick_pkg::CTRL_FLAG_BIT] = r_q.zero_flag;
      end else if (sel_reload) begin
        r_d.rdata[23:0] = r_q.reload;
      end else if (sel_current) begin
        r_d.rdata[23:0] = count;
      end else if (sel_calib) begin
        r_d.rdata[23:0] = tick_pkg::TEN_MS_DEFAULT;
      end else if (sel_stat) begin
        r_d.rdata[1:0] = r_q.irq_status;
      end else if (sel_mask) begin
        r_d.rdata[1:0] = r_q.irq_mask;
      end
    end
    if (capture && !mapped) begin
      r_d.slverr = 1'b1;
    end
  end

  // ==========================================
  // register update
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================
  // outputs
  assign PREADY = r_q.ack;
  assign PRDATA = r_q.rdata;
  assign PSLVERR = r_q.slverr;
  assign IRQ = |(r_q.irq_status & r_q.irq_mask);

  // ==========================================
  // checks
  property p_flag_set;
    @(posedge CLK) disable iff (RST)
      zero_hit |=> r_q.zero_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on zero");

  property p_flag_read_clear;
    @(posedge CLK) disable iff (RST)
      (rd_capture && sel_ctrl && !zero_hit) |=> !r_q.zero_flag;
  endproperty
  a_flag_read_clear: assert property (p_flag_read_clear) else $error("flag not cleared");

  property p_wr_clear;
    @(posedge CLK) disable iff (RST)
      (clear_count && !zero_hit) |=> (count == 24'h00_0000) && !r_q.zero_flag;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("current write did not clear");

  property p_no_int;
    @(posedge CLK) disable iff (RST)
      (zero_hit && !r_q.int_en && !r_q.irq_status[1]) |=> !r_q.irq_status[1];
  endproperty
  a_no_int: assert property (p_no_int) else $error("tick request while disabled");

  property p_int;
    @(posedge CLK) disable iff (RST)
      (zero_hit && r_q.int_en) |=> r_q.irq_status[1];
  endproperty
  a_int: assert property (p_int) else $error("tick request missing");

  property p_cur_read;
    @(posedge CLK) disable iff (RST)
      (rd_capture && sel_current) |=> (PRDATA == {8'h00, $past(count)});
  endproperty
  a_cur_read: assert property (p_cur_read) else $error("current read wrong");

  property p_ctrl_read;
    @(posedge CLK) disable iff (RST)
      (rd_access && sel_ctrl) |-> PRDATA[tick_pkg::CTRL_FIXED_BIT];
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control bit 2 not one");

  property p_calib_read;
    @(posedge CLK) disable iff (RST)
      (rd_access && sel_calib) |-> (PRDATA[31:30] == 2'h0) && (PRDATA[23:0] != 24'h0);
  endproperty
  a_calib_read: assert property (p_calib_read) else $error("calibration read wrong");

  property p_tick_spacing;
    @(posedge CLK) disable iff (RST)
      (zero_hit && r_q.run && !clear_count && r_q.reload == 24'h00_0002) ##1
        (r_q.run && !clear_count && !(wr_access && sel_reload))[*3] |-> zero_hit;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick period wrong");

  property p_hit_at_zero;
    @(posedge CLK) disable iff (RST)
      zero_hit |-> (count == 24'h00_0000);
  endproperty
  a_hit_at_zero: assert property (p_hit_at_zero) else $error("tick away from zero");

  property p_single_tick;
    @(posedge CLK) disable iff (RST)
      zero_hit |=> !zero_hit;
  endproperty
  a_single_tick: assert property (p_single_tick) else $error("tick repeated");

  property p_no_early_tick;
    @(posedge CLK) disable iff (RST)
      (r_q.run && !clear_count && count > 24'h00_0001) |=> !zero_hit;
  endproperty
  a_no_early_tick: assert property (p_no_early_tick) else $error("tick before zero");

  property p_hit_only_running;
    @(posedge CLK) disable iff (RST)
      zero_hit |-> ($past(r_q.run) && !$past(clear_count));
  endproperty
  a_hit_only_running: assert property (p_hit_only_running) else $error("tick while held");

  property p_run_write;
    @(posedge CLK) disable iff (RST)
      (wr_access && sel_ctrl) |=> (r_q.run == $past(PWDATA[tick_pkg::CTRL_ENABLE_BIT]));
  endproperty
  a_run_write: assert property (p_run_write) else $error("run bit not written");

  property p_int_en_write;
    @(posedge CLK) disable iff (RST)
      (wr_access && sel_ctrl) |=> (r_q.int_en == $past(PWDATA[tick_pkg::CTRL_INT_EN_BIT]));
  endproperty
  a_int_en_write: assert property (p_int_en_write) else $error("enable not written");

  property p_irq_clear;
    @(posedge CLK) disable iff (RST)
      (wr_access && sel_stat && (PWDATA[1:0] == 2'h3) && !zero_hit) |=> !IRQ;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("request not cleared");

  property p_irq_masked;
    @(posedge CLK) disable iff (RST)
      (r_q.irq_mask == 2'h0) |-> !IRQ;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked request seen");

  property p_status_sticky;
    @(posedge CLK) disable iff (RST)
      (!zero_hit && !(wr_access && sel_stat)) |=> $stable(r_q.irq_status);
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status moved");

  property p_flag_hold;
    @(posedge CLK) disable iff (RST)
      (!zero_hit && !(rd_capture && sel_ctrl) && !clear_count) |=> $stable(r_q.zero_flag);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag moved");

  property p_ctrl_flag_read;
    @(posedge CLK) disable iff (RST)
      (rd_capture && sel_ctrl) |=> (PRDATA[tick_pkg::CTRL_FLAG_BIT] == $past(r_q.zero_flag));
  endproperty
  a_ctrl_flag_read: assert property (p_ctrl_flag_read) else $error("flag read wrong");

  property p_reload_after_hit;
    @(posedge CLK) disable iff (RST)
      (zero_hit && r_q.run && !clear_count) |=> (count == $past(r_q.reload));
  endproperty
  a_reload_after_hit: assert property (p_reload_after_hit) else $error("no reload");

  property p_reload_write;
    @(posedge CLK) disable iff (RST)
      (wr_access && sel_reload) |=> (r_q.reload == $past(PWDATA[23:0]));
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("reload not written");

  property p_reload_read;
    @(posedge CLK) disable iff (RST)
      (rd_capture && sel_reload) |=> (PRDATA == {8'h00, $past(r_q.reload)});
  endproperty
  a_reload_read: assert property (p_reload_read) else $error("reload read wrong");

  property p_calib_default;
    @(posedge CLK) disable iff (RST)
      (rd_access && sel_calib) |-> (PRDATA[23:0] == tick_pkg::TEN_MS_DEFAULT);
  endproperty
  a_calib_default: assert property (p_calib_default) else $error("default reload wrong");

  property p_calib_top;
    @(posedge CLK) disable iff (RST)
      (rd_access && sel_calib) |-> (PRDATA[31:24] == 8'h00);
  endproperty
  a_calib_top: assert property (p_calib_top) else $error("calibration top bits set");
endmodule // system_tick_timer

/* File: design/tick_counter.sv */
`timescale 1ns/1ps
// ==========================================
// down counter core
module tick_counter #(
  parameter int WIDTH = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic clear,
  input wire logic [WIDTH-1:0] reload,
  output logic [WIDTH-1:0] count,
  output logic zero_hit
);
  // refuse widths the counter cannot serve
  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("tick_counter: bad WIDTH");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic hit;
  } cnt_state_s;

  cnt_state_s s_q, s_d;

  // next count: reload at zero, else decrement
  always_comb begin
    s_d = s_q;
    s_d.hit = 1'b0;
    if (clear) begin
      s_d.cnt = '0;
    end else if (enable) begin
      if (s_q.cnt == '0) begin
        s_d.cnt = reload;
      end else begin
        s_d.cnt = s_q.cnt - 1'b1;
        s_d.hit = (s_q.cnt == {{(WIDTH-1){1'b0}}, 1'b1});
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
  assign zero_hit = s_q.hit;

  property p_dec;
    @(posedge clk) disable iff (rst)
      (enable && !clear && count != '0) |=> (count == $past(count) - 1'b1);
  endproperty
  a_dec: assert property (p_dec) else $error("counter did not step down");

  property p_hold;
    @(posedge clk) disable iff (rst)
      (!enable && !clear) |=> $stable(count);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved while off");

  property p_reload;
    @(posedge clk) disable iff (rst)
      (enable && !clear && count == '0) |=> (count == $past(reload));
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed");
endmodule // tick_counter

/* File: design/tick_pkg.sv */
package tick_pkg;
  // ==========================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFF_CTRL = 12'h010;
  localparam logic [11:0] OFF_RELOAD = 12'h014;
  localparam logic [11:0] OFF_CURRENT = 12'h018;
  localparam logic [11:0] OFF_CALIB = 12'h01c;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h020;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h024;
  // ==========================================
  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_INT_EN_BIT = 1;
  localparam int CTRL_FIXED_BIT = 2;
  localparam int CTRL_FLAG_BIT = 16;
  localparam int CALIB_SKEW_BIT = 30;
  localparam int CALIB_NO_REF_CLK_BIT = 31;
  localparam int COUNT_W = 24;
  // ==========================================
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam logic [23:0] RELOAD_RESET = 24'h00_0000;
  localparam logic [23:0] CURRENT_RESET = 24'h00_0000;
  localparam logic [23:0] TEN_MS_DEFAULT = 24'h0f_423f;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  // ==========================================
  // timing: 10 ms tick at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_MS = 10;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
endpackage

/* File: tb/system_tick_timer_tb.sv */
`timescale 1ns/1ps
// ==========================================
// bench for the tick timer
module system_tick_timer_tb;
  logic CLK, RST, PSEL, PENABLE, PWRITE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic PREADY, PSLVERR, IRQ;
  int err_count = 0;
  int total_checks = 0;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [23:0] rld;

  system_tick_timer u_system_tick_timer (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ)
  );

  // clock generator
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // ==========================================
  // shared tasks
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, want);
    end
  endtask

  // one apb transfer, entered right after a rising edge
  task automatic xfer(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] x, input logic er);
    exp_q.push_back({~is_wr, er, x});
    PSEL <= 1'b1;
    PWRITE <= is_wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    // hold the request until pready is sampled high; the watchdog ends a hang
    while (PREADY !== 1'b1) begin
      @(posedge CLK);
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0, x, 1'b0);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (IRQ !== 1'b1 && n < 500) begin
      @(posedge CLK);
      n++;
    end
    check({31'h0, IRQ}, 32'h1);
  endtask

  // monitor: compare each completed transfer with the oldest note
  always @(posedge CLK) begin
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1) begin
      e = exp_q.pop_front();
      check({31'h0, PSLVERR}, {31'h0, e[32]});
      if (e[33]) begin
        check(PRDATA, e[31:0]);
      end
    end
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge CLK);
    err_count++;
    complete_run();
  end

  // ==========================================
  // main sequence
  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    void'($urandom(32'h96e5));
    rld = 24'h20 + 24'($urandom % 64);
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    check({31'h0, IRQ}, 32'h0);
    rd(tick_pkg::OFF_CTRL, tick_pkg::CTRL_RESET);
    rd(tick_pkg::OFF_RELOAD, 32'h0);
    rd(tick_pkg::OFF_CURRENT, 32'h0);
    rd(tick_pkg::OFF_CALIB, {8'h00, tick_pkg::TEN_MS_DEFAULT});
    rd(tick_pkg::OFF_IRQ_STATUS, 32'h0);
    rd(tick_pkg::OFF_IRQ_MASK, 32'h0);
    wr(tick_pkg::OFF_CALIB, 32'h0000_1234);
    rd(tick_pkg::OFF_CALIB, {8'h00, tick_pkg::TEN_MS_DEFAULT});
    xfer(1'b1, 12'h030, $urandom, 32'h0, 1'b1);
    xfer(1'b0, 12'h030, 32'h0, 32'h0, 1'b1);
    wr(tick_pkg::OFF_RELOAD, {8'h00, rld});
    rd(tick_pkg::OFF_RELOAD, {8'h00, rld});
    // run for one load and three steps, then hold
    wr(tick_pkg::OFF_CTRL, 32'h1);
    wr(tick_pkg::OFF_CTRL, 32'h0);
    rd(tick_pkg::OFF_CURRENT, {8'h00, rld - 24'd3});
    rd(tick_pkg::OFF_CURRENT, {8'h00, rld - 24'd3});
    // tick interrupt through the mask
    wr(tick_pkg::OFF_IRQ_MASK, 32'h2);
    wr(tick_pkg::OFF_CTRL, 32'h3);
    wait_irq();
    rd(tick_pkg::OFF_IRQ_STATUS, 32'h3);
    rd(tick_pkg::OFF_CTRL, 32'h0001_0007);
    rd(tick_pkg::OFF_CTRL, 32'h0000_0007);
    wr(tick_pkg::OFF_IRQ_STATUS, 32'h3);
    check({31'h0, IRQ}, 32'h0);
    // masked events stay silent
    wr(tick_pkg::OFF_IRQ_MASK, 32'h0);
    repeat (100) @(posedge CLK);
    check({31'h0, IRQ}, 32'h0);
    rd(tick_pkg::OFF_IRQ_STATUS, 32'h3);
    // no request with interrupt enable clear
    wr(tick_pkg::OFF_CTRL, 32'h1);
    wr(tick_pkg::OFF_IRQ_STATUS, 32'h3);
    repeat (100) @(posedge CLK);
    rd(tick_pkg::OFF_IRQ_STATUS, 32'h1);
    // current write clears count and flag
    wr(tick_pkg::OFF_CTRL, 32'h0);
    wr(tick_pkg::OFF_CURRENT, {8'h00, 24'($urandom)});
    rd(tick_pkg::OFF_CURRENT, 32'h0);
    rd(tick_pkg::OFF_CTRL, 32'h4);
    // short period: a tick every third cycle
    wr(tick_pkg::OFF_RELOAD, 32'h2);
    wr(tick_pkg::OFF_IRQ_STATUS, 32'h3);
    wr(tick_pkg::OFF_CTRL, 32'h1);
    repeat (20) @(posedge CLK);
    rd(tick_pkg::OFF_IRQ_STATUS, 32'h1);
    rd(tick_pkg::OFF_CTRL, 32'h0001_0005);
    complete_run();
  end
endmodule // system_tick_timer_tb
